/* File: fsap_map.vh */
// Constants for the flash status register and array protection block
// Behaviour
// - op_in_progress (S0) is 1 while program, erase or status write runs.
// - write_latch (S1) reported; when 0, status write, program, erase refused.
// - region_select S6..S2 written by status write; protected region refuses program/erase.
// - region_select updates only when hardware protection is not in force.
// - Chip erase only if low select bits 000 with invert 0, or 111 with invert 1.
// - With invert_region 1 the complement of the normal region is protected.
// - invert_region at S14, default 0, combined with region_select for decoding.
// - Guard S8:S7: 00 open, 01 pin-locked, 10 lock to power cycle, 11 permanent.
// - Guard value 10 returns to 00 across a power cycle.
// - four_lane_enable S9: 0 keeps protect/pause pins as controls, 1 makes them lanes.
// - Three one-time lock bits S13..S11 default 0, set individually, never cleared.
// - A set lock bit makes its security register refuse program and erase.
// - Suspend sets erase_paused S15 or program_paused S10 by suspended operation.
// - Resume, software reset and power cycle clear both suspend flags.
// - With invert_region 0 the decoded region itself is protected.
// - write_latch cleared by power-up, reset, write disable, accepted program/erase and completed status write.
// - protect_pin_n low with guard 01 and four_lane_enable 0 is hardware protection shielding select and guard bits.
`ifndef FSAP_MAP_VH
`define FSAP_MAP_VH
// Command codes
`define FSAP_CMD_WR_EN 8'h06
`define FSAP_CMD_WRDI 8'h04
`define FSAP_CMD_SR_WRITE 8'h01
`define FSAP_CMD_PROG 8'h02
`define FSAP_CMD_QPP 8'h32
`define FSAP_CMD_SECT 8'h20
`define FSAP_CMD_BE32 8'h52
`define FSAP_CMD_BE64 8'hd8
`define FSAP_CMD_CE1 8'h60
`define FSAP_CMD_CE2 8'hc7
`define FSAP_CMD_SECER 8'h44
`define FSAP_CMD_SECPG 8'h42
`define FSAP_CMD_SUSP 8'h75
`define FSAP_CMD_RESUME 8'h7a
`define FSAP_CMD_RSTEN 8'h66
`define FSAP_CMD_RST 8'h99
// Status bit positions
`define FSAP_BIT_BUSY 0
`define FSAP_BIT_LATCH 1
`define FSAP_BIT_ERS_SUS 15
`define FSAP_BIT_PGM_SUS 10
`define FSAP_BIT_INV 14
`define FSAP_BIT_LANES 9
// Array operation kinds
`define FSAP_OP_PROG 3'h0
`define FSAP_OP_SECT 3'h1
`define FSAP_OP_BE32 3'h2
`define FSAP_OP_BE64 3'h3
`define FSAP_OP_CE 3'h4
`define FSAP_OP_SECER 3'h5
`define FSAP_OP_SECPG 3'h6
// Region sizes in 4KB sectors
`define FSAP_SECTORS 12'h800
`define FSAP_FRAC_BASE 12'h020
`define FSAP_PIECE_MAX 12'h008
// Status write busy time
`define FSAP_CLK_NS 20
`define FSAP_SRW_TIME_NS 5000
`define FSAP_SRW_CYC ((`FSAP_SRW_TIME_NS + `FSAP_CLK_NS - 1) / `FSAP_CLK_NS)
`endif

/* File: fsap_status_protect.v */
// Status registers, command intake and array protection of a serial flash
`include "fsap_map.vh"

module fsap_status_protect #(
    parameter ADDR_W = 23,
    parameter SRW_CYC = `FSAP_SRW_CYC
) (
    // Clock and power-up reset
    input wire ref_clk,
    input wire rst_n,
    // Serial link pins
    input wire sclk,
    input wire cs_n,
    input wire si,
    input wire protect_pin_n,
    // Array engine
    output reg array_start,
    output reg [2:0] array_kind,
    output reg [ADDR_W-1:0] array_addr,
    output reg array_pause,
    output reg array_resume,
    input wire array_done,
    // Status view
    output reg [7:0] status_low,
    output reg [7:0] status_high,
    output reg pins_as_lanes
);

    // Region decode: 1 when the sector lies in the protected range
    function prot_sector;
        input [4:0] sel;
        input inv;
        input [10:0] sec;
        reg [11:0] n;
        reg hit;
        begin
            n = 12'h000;
            hit = 1'b0;
            if (sel[4] == 1'b0)
                n = `FSAP_FRAC_BASE << (sel[2:0] - 3'h1);
            else if (sel[2])
                n = `FSAP_PIECE_MAX;
            else
                n = 12'h001 << (sel[1:0] - 2'h1);
            if (sel[3])
                hit = {1'b0, sec} < n;
            else
                hit = {1'b0, sec} >= (`FSAP_SECTORS - n);
            if (sel[2:0] == 3'h0)
                hit = 1'b0;
            else if (sel[2:0] == 3'h7)
                hit = 1'b1;
            prot_sector = hit ^ inv;
        end
    endfunction

    // Link synchronisers and edge finders
    reg [1:0] sclk_s;
    reg [1:0] cs_s;
    reg [1:0] si_s;
    reg [1:0] wp_s;
    reg sclk_d;
    reg cs_d;
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sclk_s <= 2'h0;
            cs_s <= 2'h3;
            si_s <= 2'h0;
            wp_s <= 2'h3;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end
        else
        begin
            sclk_s <= {sclk_s[0], sclk};
            cs_s <= {cs_s[0], cs_n};
            si_s <= {si_s[0], si};
            wp_s <= {wp_s[0], protect_pin_n};
            sclk_d <= sclk_s[1];
            cs_d <= cs_s[1];
        end
    end
    wire sclk_rise = sclk_s[1] & ~sclk_d & ~cs_s[1];
    wire frame_end = cs_s[1] & ~cs_d;

    // Byte intake
    reg [7:0] shifter;
    reg [2:0] bit_cnt;
    reg [2:0] byte_cnt;
    reg [7:0] opcode;
    reg [7:0] byte1;
    reg [7:0] byte2;
    reg [7:0] byte3;
    wire [7:0] next_shift = {shifter[6:0], si_s[1]};
    always @(posedge ref_clk)
    begin
        if (!rst_n || (cs_s[1] && !frame_end))
        begin
            shifter <= 8'h00;
            bit_cnt <= 3'h0;
            byte_cnt <= 3'h0;
            opcode <= 8'h00;
            byte1 <= 8'h00;
            byte2 <= 8'h00;
            byte3 <= 8'h00;
        end
        else if (sclk_rise)
        begin
            shifter <= next_shift;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
                case (byte_cnt)
                    3'h0: opcode <= next_shift;
                    3'h1: byte1 <= next_shift;
                    3'h2: byte2 <= next_shift;
                    3'h3: byte3 <= next_shift;
                    default: ;
                endcase
                if (byte_cnt != 3'h7)
                    byte_cnt <= byte_cnt + 3'h1;
            end
        end
    end

    // Status state; non-volatile bits start at defaults and survive rst_n, except guard 10
    reg busy;
    reg write_latch;
    reg [4:0] sel = 5'h00;
    reg [1:0] guard = 2'h0;
    reg four_lane = 1'b0;
    reg [2:0] lock = 3'h0;
    reg inv = 1'b0;
    reg ers_sus;
    reg pgm_sus;
    reg susp_erase;
    reg srw_run;
    reg [15:0] srw_cnt;
    reg rst_armed;

    wire [23:0] cmd_addr = {byte1, byte2, byte3};
    wire [10:0] sec_first = cmd_addr[22:12];
    wire [10:0] blk64_last = {cmd_addr[22:16], 4'hf};
    wire [10:0] blk32_last = {cmd_addr[22:15], 3'h7};
    wire [1:0] sec_idx = cmd_addr[13:12];
    // With four lanes the protect pin is data and no longer locks
    wire hw_prot = guard == 2'h1 && !wp_s[1] && !four_lane;
    wire sr_open = guard == 2'h0 || (guard == 2'h1 && !hw_prot);
    wire sec_locked = sec_idx == 2'h0 || lock[sec_idx - 2'h1];
    wire ce_ok = (sel[2:0] == 3'h0 && !inv) || (sel[2:0] == 3'h7 && inv);
    wire exec = frame_end && bit_cnt == 3'h0 && byte_cnt != 3'h0;
    wire one_byte = exec && byte_cnt == 3'h1;
    wire idle = !busy && !ers_sus && !pgm_sus;

    // Decode a write-class command into an array start
    reg go;
    reg [2:0] kind;
    always @*
    begin
        go = 1'b0;
        kind = `FSAP_OP_PROG;
        case (opcode)
            `FSAP_CMD_PROG, `FSAP_CMD_QPP:
            begin
                kind = `FSAP_OP_PROG;
                go = byte_cnt >= 3'h5 && !prot_sector(sel, inv, sec_first);
            end
            `FSAP_CMD_SECT:
            begin
                kind = `FSAP_OP_SECT;
                go = byte_cnt == 3'h4 && !prot_sector(sel, inv, sec_first);
            end
            `FSAP_CMD_BE32:
            begin
                kind = `FSAP_OP_BE32;
                go = byte_cnt == 3'h4 && !prot_sector(sel, inv, sec_first)
                    && !prot_sector(sel, inv, blk32_last);
            end
            `FSAP_CMD_BE64:
            begin
                kind = `FSAP_OP_BE64;
                go = byte_cnt == 3'h4 && !prot_sector(sel, inv, sec_first)
                    && !prot_sector(sel, inv, blk64_last);
            end
            `FSAP_CMD_CE1, `FSAP_CMD_CE2:
            begin
                kind = `FSAP_OP_CE;
                go = byte_cnt == 3'h1 && ce_ok;
            end
            `FSAP_CMD_SECER:
            begin
                kind = `FSAP_OP_SECER;
                go = byte_cnt == 3'h4 && !sec_locked;
            end
            `FSAP_CMD_SECPG:
            begin
                kind = `FSAP_OP_SECPG;
                go = byte_cnt >= 3'h5 && !sec_locked;
            end
            default: ;
        endcase
        go = go && write_latch && idle && exec;
    end

    wire srw_go = exec && opcode == `FSAP_CMD_SR_WRITE && write_latch && idle && sr_open
        && (byte_cnt == 3'h2 || byte_cnt == 3'h3);

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            // Power cycle: volatile bits clear, guard 10 falls back to 00
            busy <= 1'b0;
            write_latch <= 1'b0;
            if (guard == 2'h2)
                guard <= 2'h0;
            ers_sus <= 1'b0;
            pgm_sus <= 1'b0;
            susp_erase <= 1'b0;
            srw_run <= 1'b0;
            srw_cnt <= 16'h0000;
            rst_armed <= 1'b0;
            array_start <= 1'b0;
            array_kind <= `FSAP_OP_PROG;
            array_addr <= {ADDR_W{1'b0}};
            array_pause <= 1'b0;
            array_resume <= 1'b0;
        end
        else
        begin
            array_start <= go;
            array_pause <= 1'b0;
            array_resume <= 1'b0;
            if (exec)
                rst_armed <= opcode == `FSAP_CMD_RSTEN && byte_cnt == 3'h1;
            if (go)
            begin
                busy <= 1'b1;
                write_latch <= 1'b0;
                array_kind <= kind;
                array_addr <= cmd_addr[ADDR_W-1:0];
                susp_erase <= kind != `FSAP_OP_PROG && kind != `FSAP_OP_SECPG;
            end
            if (srw_go)
            begin
                busy <= 1'b1;
                srw_run <= 1'b1;
                srw_cnt <= SRW_CYC[15:0];
                sel <= byte1[6:2];
                guard[0] <= byte1[7];
                if (byte_cnt == 3'h3)
                begin
                    // Read-only positions of the data are ignored
                    guard[1] <= byte2[0];
                    four_lane <= byte2[1];
                    lock <= lock | byte2[5:3];
                    inv <= byte2[6];
                end
            end
            if (srw_run)
            begin
                if (srw_cnt == 16'h0001)
                begin
                    srw_run <= 1'b0;
                    busy <= 1'b0;
                    write_latch <= 1'b0;
                end
                srw_cnt <= srw_cnt - 16'h0001;
            end
            if (array_done && busy && !srw_run)
                busy <= 1'b0;
            if (one_byte && opcode == `FSAP_CMD_WR_EN)
                write_latch <= 1'b1;
            if (one_byte && opcode == `FSAP_CMD_WRDI)
                write_latch <= 1'b0;
            if (one_byte && opcode == `FSAP_CMD_SUSP && busy && !srw_run && !array_done)
            begin
                busy <= 1'b0;
                array_pause <= 1'b1;
                if (susp_erase)
                    ers_sus <= 1'b1;
                else
                    pgm_sus <= 1'b1;
            end
            if (one_byte && opcode == `FSAP_CMD_RESUME && (ers_sus || pgm_sus))
            begin
                busy <= 1'b1;
                array_resume <= 1'b1;
                ers_sus <= 1'b0;
                pgm_sus <= 1'b0;
            end
            if (one_byte && opcode == `FSAP_CMD_RST && rst_armed)
            begin
                write_latch <= 1'b0;
                ers_sus <= 1'b0;
                pgm_sus <= 1'b0;
            end
        end
    end

    // Registered status view
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            status_low <= 8'h00;
            status_high <= 8'h00;
            pins_as_lanes <= 1'b0;
        end
        else
        begin
            status_low <= {guard[0], sel, write_latch, busy};
            status_high <= {ers_sus, inv, lock, pgm_sus, four_lane, guard[1]};
            pins_as_lanes <= four_lane;
        end
    end

endmodule // fsap_status_protect

/* File: fsap_status_protect_chk.sv */
// Port assertions for the status and protection block
module fsap_status_protect_chk #(
    parameter ADDR_W = 23,
    parameter SRW_CYC = 4
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Link pins
    input wire sclk,
    input wire cs_n,
    input wire si,
    input wire protect_pin_n,
    // Array engine
    input wire array_start,
    input wire [2:0] array_kind,
    input wire [ADDR_W-1:0] array_addr,
    input wire array_pause,
    input wire array_resume,
    input wire array_done,
    // Status view
    input wire [7:0] status_low,
    input wire [7:0] status_high,
    input wire pins_as_lanes
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    start_busy_a: assert property (array_start |-> status_low[1] ##1 status_low[1:0] == 2'b01)
        else $error("busy or latch wrong after start");
    pause_idle_a: assert property (array_pause |=> !status_low[0] && (status_high[7] ^ status_high[2]))
        else $error("pause flags wrong");
    resume_busy_a: assert property (array_resume |=> status_low[0] && !status_high[7] && !status_high[2])
        else $error("resume flags wrong");
    flag_cause_a: assert property ($rose(status_high[7]) || $rose(status_high[2]) |-> $past(array_pause))
        else $error("pause flag set without suspend");
    done_idle_a: assert property (array_done && status_low[0] |-> ##2 !status_low[0])
        else $error("busy stuck after done");
    lock_sticky_a: assert property (($past(status_high[5:3]) & ~status_high[5:3]) == 3'h0)
        else $error("lock bit cleared");
    lock_gate_a: assert property (array_start && array_kind == 3'h5 |->
        array_addr[13:12] != 2'h0 && !status_high[array_addr[13:12] + 2])
        else $error("locked security area erased");
    chip_gate_a: assert property (array_start && array_kind == 3'h4 |->
        (status_low[4:2] == 3'h0 && !status_high[6]) || (status_low[4:2] == 3'h7 && status_high[6]))
        else $error("chip erase not allowed");
    guard_lock_a: assert property (status_high[0] && $past(status_high[0]) |-> $stable(status_low[6:2]))
        else $error("select bits changed under lock");
endmodule // fsap_status_protect_chk

bind fsap_status_protect fsap_status_protect_chk #(.ADDR_W(ADDR_W), .SRW_CYC(SRW_CYC)) chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .protect_pin_n(protect_pin_n), .array_start(array_start), .array_kind(array_kind),
    .array_addr(array_addr), .array_pause(array_pause), .array_resume(array_resume),
    .array_done(array_done), .status_low(status_low), .status_high(status_high),
    .pins_as_lanes(pins_as_lanes));

/* File: fsap_spi_host.sv */
// Serial host model sending mode 0 frames
module fsap_spi_host (
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic si
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Sends the top n bits of d, MSB first
    task automatic frame(input logic [39:0] d, input int n);
        #3 cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si = d[39-i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        // Released line shows no stale bit
        si = ~si;
        #400;
    endtask
endmodule // fsap_spi_host

/* File: fsap_status_protect_tb.sv */
// Self-checking bench for the status and protection block
module fsap_status_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, protect_pin_n, array_done, sclk, cs_n, si;
    logic array_start, array_pause, array_resume, pins_as_lanes;
    logic [2:0] array_kind;
    logic [22:0] array_addr;
    logic [7:0] status_low, status_high;
    logic [25:0] exp_q[$];
    logic [25:0] e;
    int err_total, checks, cnt, dur;
    logic [7:0] ops[4] = '{8'h02, 8'h20, 8'h52, 8'hd8};

    fsap_status_protect #(.SRW_CYC(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .si(si), .protect_pin_n(protect_pin_n), .array_start(array_start),
        .array_kind(array_kind), .array_addr(array_addr), .array_pause(array_pause),
        .array_resume(array_resume), .array_done(array_done), .status_low(status_low),
        .status_high(status_high), .pins_as_lanes(pins_as_lanes));
    fsap_spi_host host (.sclk(sclk), .cs_n(cs_n), .si(si));

    task automatic compare(input logic [25:0] got, input logic [25:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [15:0] exp);
        compare({10'h0, status_high, status_low}, {10'h0, exp});
    endtask
    task automatic cmd(input logic [7:0] op);
        host.frame({op, 32'h0}, 8);
    endtask
    task automatic wr(input logic [7:0] lo, input logic [7:0] hi);
        cmd(8'h06);
        host.frame({8'h01, lo, hi, 16'h0}, 24);
    endtask
    task automatic arr(input logic [7:0] op, input logic [23:0] a, input bit ok,
        input logic [2:0] k);
        cmd(8'h06);
        if (ok) exp_q.push_back({k, a[22:0]});
        host.frame({op, a, 8'h5a}, (op == 8'h60 || op == 8'hc7) ? 8 : (op == 8'h02 ? 40 : 32));
    endtask
    task automatic finish_test();
        err_total += exp_q.size();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Array engine stand-in
    always @(posedge ref_clk)
    begin
        array_done <= 1'b0;
        if (array_start === 1'b1) cnt <= dur;
        else if (array_pause === 1'b1) cnt <= 0;
        else if (array_resume === 1'b1) cnt <= 30;
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            array_done <= (cnt == 1);
        end
    end
    // Oldest expected start against each accepted operation
    always @(posedge ref_clk)
        if (array_start === 1'b1)
        begin
            e = exp_q.size() ? exp_q.pop_front() : 26'h3ffffff;
            compare({array_kind, array_addr}, e);
        end

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        #1ms;
        err_total++;
        finish_test();
    end
    initial
    begin
        rst_n = 1'b0;
        protect_pin_n = 1'b1;
        array_done = 1'b0;
        dur = 6;
        cnt = 0;
        void'($urandom(32'h9f452bcd));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(16'h0000);
        host.frame({8'h20, 24'h001000, 8'h0}, 32);
        for (int i = 0; i < 4; i++) arr(ops[i], {1'b0, 11'($urandom), 12'h0}, 1, 3'(i));
        wr(8'h04, 8'h00);
        chk(16'h0004);
        arr(8'h20, 24'h7e0000, 0, 1);
        arr(8'h20, 24'h7df000, 1, 1);
        wr(8'h04, 8'h40);
        chk(16'h4004);
        arr(8'h20, 24'h7e0000, 1, 1);
        arr(8'h20, 24'h000000, 0, 1);
        arr(8'h60, 24'h0, 0, 4);
        wr(8'h1c, 8'h48);
        arr(8'hc7, 24'h0, 1, 4);
        arr(8'h44, 24'h001000, 0, 5);
        arr(8'h44, 24'h002000, 1, 5);
        wr(8'h1f, 8'hc4);
        chk(16'h481c);
        wr(8'h9c, 8'h40);
        @(posedge ref_clk) protect_pin_n <= 1'b0;
        wr(8'h80, 8'h00);
        chk(16'h489e);
        compare({25'h0, pins_as_lanes}, 26'h0);
        @(posedge ref_clk) protect_pin_n <= 1'b1;
        wr(8'h00, 8'h08);
        chk(16'h0800);
        wr(8'h80, 8'h02);
        compare({25'h0, pins_as_lanes}, 26'h1);
        chk(16'h0a80);
        @(posedge ref_clk) protect_pin_n <= 1'b0;
        wr(8'h00, 8'h08);
        chk(16'h0800);
        @(posedge ref_clk) protect_pin_n <= 1'b1;
        dur = 2000;
        arr(8'h20, 24'h010000, 1, 1);
        cmd(8'h75);
        chk(16'h8800);
        cmd(8'h7a);
        chk(16'h0801);
        repeat (30) @(posedge ref_clk);
        arr(8'h02, 24'h020000, 1, 0);
        cmd(8'h75);
        chk(16'h0c00);
        cmd(8'h66);
        cmd(8'h99);
        chk(16'h0800);
        dur = 6;
        wr(8'h00, 8'h01);
        wr(8'h1c, 8'h00);
        chk(16'h0902);
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(16'h0800);
        finish_test();
    end
endmodule // fsap_status_protect_tb
